// ### shared/acqd_pkg.sv
// shared constants and types for the acquisition display controller
package acqd_pkg;

  // channel count and serial framing
  localparam int NUM_CH = 2;
  localparam int FRAME_BITS = 10;

  // communication settings
  localparam logic [7:0] ADDR_DEFAULT = 8'h01;
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [3:0] BAUD_9600 = 4'h6;
  localparam logic [3:0] BAUD_MIN = 4'h1;
  localparam logic [3:0] BAUD_MAX = 4'h8;

  // timing: clock rate and display intervals in milliseconds
  localparam int CLK_HZ = 50_000_000;
  localparam int DWELL_MS = 1000;
  localparam int CODE_MS = 1000;
  localparam int DWELL_CYCLES = CLK_HZ / 1000 * DWELL_MS;
  localparam int CODE_CYCLES = CLK_HZ / 1000 * CODE_MS;
  // strap sampling waits for the synchroniser to fill
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // display glyph codes (0..9 are plain decimal digits)
  localparam logic [3:0] GLYPH_C = 4'hC;
  localparam logic [3:0] GLYPH_BLANK = 4'hF;

  typedef enum logic {ACQD_PROTO_ASCII, ACQD_PROTO_MODBUS} acqd_proto_t;

  typedef enum logic [2:0] {
    ACQD_CMD_CONFIG,
    ACQD_CMD_SET_PROTO,
    ACQD_CMD_OFFSET_CAL,
    ACQD_CMD_GAIN_CAL
  } acqd_cmd_kind_t;

  // live communication settings
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] baud;
    logic cksum_en;
    acqd_proto_t proto;
  } acqd_cfg_t;

  // one decoded command from the serial front end
  typedef struct packed {
    acqd_cmd_kind_t kind;
    logic chan;
    logic [7:0] new_addr;
    logic [3:0] baud;
    logic cksum_en;
    acqd_proto_t proto;
  } acqd_cmd_t;

  // one displayable reading: sign, three bcd digits, point position
  typedef struct packed {
    logic positive;
    logic [11:0] bcd;
    logic [1:0] dp_pos;
  } acqd_reading_t;

  // four digit readout, digit 3 is leftmost
  typedef struct packed {
    logic [3:0][3:0] glyph;
    logic [3:0] dp;
    logic on;
  } acqd_disp_t;

  // clock cycles per bit for a baud code, zero for an illegal code
  function automatic logic [19:0] acqd_bit_cycles(input logic [3:0] code);
    case (code)
      4'h1: acqd_bit_cycles = 20'(CLK_HZ / 300);
      4'h2: acqd_bit_cycles = 20'(CLK_HZ / 600);
      4'h3: acqd_bit_cycles = 20'(CLK_HZ / 1200);
      4'h4: acqd_bit_cycles = 20'(CLK_HZ / 2400);
      4'h5: acqd_bit_cycles = 20'(CLK_HZ / 4800);
      4'h6: acqd_bit_cycles = 20'(CLK_HZ / 9600);
      4'h7: acqd_bit_cycles = 20'(CLK_HZ / 19200);
      4'h8: acqd_bit_cycles = 20'(CLK_HZ / 38400);
      default: acqd_bit_cycles = 20'h00000;
    endcase
  endfunction

endpackage

// ### rtl/acqd_pin_sync.sv
// two-flop synchroniser for an active-low pin with press detection
`timescale 1ns/100ps
module acqd_pin_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // raw pin, active low
  input wire logic pin_n,
  // synchronised level and one-cycle press pulse
  output logic level_n,
  output logic press
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // only sync_r reads meta_r; pins idle high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= pin_n;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // press is the falling edge of the synchronised level
  assign level_n = sync_r;
  assign press = prev_r & ~sync_r;

endmodule // acqd_pin_sync

// ### rtl/acqd_top.sv
// acquisition module control: config state, calibration, led readout
//
// Behaviour
// - Unconfigured power-up: address 01H, 9600 baud, no checksum, ASCII.
// - Node address is eight bits; host gives every module a distinct address.
// - Strap low at power-up: config state, 00H, 9600, no checksum, ASCII.
// - Baud, checksum and protocol change only while in config state.
// - Node address is rewritten by a configuration command unless the command's baud or checksum change is refused.
// - In config state the host selects ASCII or Modbus RTU.
// - Calibration commands run only under the ASCII protocol.
// - Offset command for channel 0 or 1 stores present reading as zero.
// - Gain command stores present reading as 120 percent of full scale.
// - Leftmost digit shows channel 1 or 2, then three decimal digits.
// - Point after the channel digit lit for positive, dark for negative.
// - Mode key steps views, including display off.
// - A mode press into single or cyclic view briefly shows that view's code, then data resumes.
// - Single view: left key adds one to channel, right key subtracts one.
// - Cyclic view advances channel after a fixed dwell interval.
// - Characters are start, eight data, stop: ten bit times.
`timescale 1ns/100ps
module acqd_top #(
  parameter int DWELL_CYCLES = acqd_pkg::DWELL_CYCLES,
  parameter int CODE_CYCLES = acqd_pkg::CODE_CYCLES,
  parameter int SAMPLE_W = 24
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // configuration strap pin, grounded for config state
  input wire logic cfg_strap_n,
  // settings recalled from non-volatile storage
  input wire logic nv_cfg_valid,
  input wire acqd_pkg::acqd_cfg_t nv_cfg,
  // decoded commands from the serial front end
  input wire logic cmd_valid,
  input wire acqd_pkg::acqd_cmd_t cmd,
  output logic cmd_ok,
  output logic cmd_err,
  // live settings for the serial front end
  output acqd_pkg::acqd_cfg_t cfg,
  output logic config_state,
  output logic [23:0] char_cycles,
  // converter samples and their display form
  input wire logic [acqd_pkg::NUM_CH-1:0][SAMPLE_W-1:0] raw_sample,
  input wire acqd_pkg::acqd_reading_t [acqd_pkg::NUM_CH-1:0] reading,
  // stored calibration points
  output logic [acqd_pkg::NUM_CH-1:0][SAMPLE_W-1:0] zero_pt,
  output logic [acqd_pkg::NUM_CH-1:0][SAMPLE_W-1:0] span_pt,
  // front panel keys, active low
  input wire logic key_mode_n,
  input wire logic key_left_n,
  input wire logic key_right_n,
  // led readout
  output acqd_pkg::acqd_disp_t disp
);

  localparam int DW = $clog2(DWELL_CYCLES + 1);
  localparam int CW = $clog2(CODE_CYCLES + 1);

  // parameters the counters cannot serve
  if (DWELL_CYCLES < 1 || CODE_CYCLES < 1 || SAMPLE_W < 1) begin : g_chk
    $error("acqd_top: cycle counts and sample width must be positive");
  end

  typedef enum logic [1:0] {
    ACQD_VIEW_SINGLE,
    ACQD_VIEW_CYCLIC,
    ACQD_VIEW_OFF
  } acqd_view_t;

  // channel step with wrap in either direction
  function automatic logic step_ch(input logic ch, input logic up);
    logic [1:0] n;
    n = up ? 2'({1'b0, ch}) + 2'h1 : 2'({1'b0, ch}) + 2'(acqd_pkg::NUM_CH - 1);
    step_ch = (n >= 2'(acqd_pkg::NUM_CH)) ? n[0] ^ 1'b0 : n[0];
  endfunction

  // pin synchronisers
  logic strap_lvl_n;
  logic mode_press;
  logic left_press;
  logic right_press;

  acqd_pin_sync u_strap (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_n(cfg_strap_n),
    .level_n(strap_lvl_n),
    .press()
  );
  acqd_pin_sync u_mode (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_n(key_mode_n),
    .level_n(),
    .press(mode_press)
  );
  acqd_pin_sync u_left (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_n(key_left_n),
    .level_n(),
    .press(left_press)
  );
  acqd_pin_sync u_right (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_n(key_right_n),
    .level_n(),
    .press(right_press)
  );

  // ---------------- power-up strap capture and settings ----------------
  logic [1:0] settle_r;
  logic captured_r;
  logic cfg_mode_r;
  acqd_pkg::acqd_cfg_t cfg_r;
  acqd_pkg::acqd_cfg_t cfg_nxt;
  acqd_pkg::acqd_cfg_t boot_cfg;
  acqd_pkg::acqd_cfg_t cfg_default;
  acqd_pkg::acqd_cfg_t cfg_config;
  logic ok_nxt;
  logic err_nxt;
  logic capture;
  logic comm_change;
  logic baud_legal;
  logic is_ascii;

  // factory and config-state settings
  assign cfg_default = '{addr: acqd_pkg::ADDR_DEFAULT,
                         baud: acqd_pkg::BAUD_9600, cksum_en: 1'b0,
                         proto: acqd_pkg::ACQD_PROTO_ASCII};
  assign cfg_config = '{addr: acqd_pkg::ADDR_CONFIG,
                        baud: acqd_pkg::BAUD_9600, cksum_en: 1'b0,
                        proto: acqd_pkg::ACQD_PROTO_ASCII};
  // strap wins over stored settings
  assign boot_cfg = !strap_lvl_n ? cfg_config :
                    (nv_cfg_valid ? nv_cfg : cfg_default);
  assign capture = !captured_r && (settle_r == acqd_pkg::STRAP_SETTLE);

  // command qualification
  assign is_ascii = (cfg_r.proto == acqd_pkg::ACQD_PROTO_ASCII);
  assign comm_change = (cmd.baud != cfg_r.baud) ||
                       (cmd.cksum_en != cfg_r.cksum_en);
  assign baud_legal = (cmd.baud >= acqd_pkg::BAUD_MIN) &&
                      (cmd.baud <= acqd_pkg::BAUD_MAX);

  // next settings and answer; a refused command changes nothing
  always_comb begin
    cfg_nxt = cfg_r;
    ok_nxt = 1'b0;
    err_nxt = 1'b0;
    if (capture) begin
      cfg_nxt = boot_cfg;
    end else if (cmd_valid && captured_r) begin
      case (cmd.kind)
        acqd_pkg::ACQD_CMD_CONFIG: begin
          if (comm_change && (!cfg_mode_r || !baud_legal)) begin
            err_nxt = 1'b1;
          end else begin
            cfg_nxt.addr = cmd.new_addr;
            cfg_nxt.baud = cmd.baud;
            cfg_nxt.cksum_en = cmd.cksum_en;
            ok_nxt = 1'b1;
          end
        end
        acqd_pkg::ACQD_CMD_SET_PROTO: begin
          if (cfg_mode_r) begin
            cfg_nxt.proto = cmd.proto;
            ok_nxt = 1'b1;
          end else begin
            err_nxt = 1'b1;
          end
        end
        acqd_pkg::ACQD_CMD_OFFSET_CAL,
        acqd_pkg::ACQD_CMD_GAIN_CAL: begin
          ok_nxt = is_ascii;
          err_nxt = !is_ascii;
        end
        default: err_nxt = 1'b1;
      endcase
    end
  end

  // settings registers; config state lasts until the next power-up
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      settle_r <= 2'h0;
      captured_r <= 1'b0;
      cfg_mode_r <= 1'b0;
      cfg_r <= '{addr: acqd_pkg::ADDR_DEFAULT, baud: acqd_pkg::BAUD_9600,
                 cksum_en: 1'b0, proto: acqd_pkg::ACQD_PROTO_ASCII};
      cmd_ok <= 1'b0;
      cmd_err <= 1'b0;
    end else begin
      if (!captured_r) settle_r <= settle_r + 2'h1;
      if (capture) captured_r <= 1'b1;
      if (capture) cfg_mode_r <= !strap_lvl_n;
      cfg_r <= cfg_nxt;
      cmd_ok <= ok_nxt;
      cmd_err <= err_nxt;
    end
  end

  assign cfg = cfg_r;
  assign config_state = cfg_mode_r;

  // character time for the uart: ten bit times per frame
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      char_cycles <= 24'h000000;
    end else begin
      char_cycles <= 24'(acqd_pkg::FRAME_BITS) *
                     24'(acqd_pkg::acqd_bit_cycles(cfg_r.baud));
    end
  end

  // ---------------- calibration points ----------------
  logic cal_go;
  assign cal_go = cmd_valid && captured_r && is_ascii;

  // reading is taken once the host reports the input settled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      zero_pt <= '0;
      span_pt <= '0;
    end else if (cal_go) begin
      if (cmd.kind == acqd_pkg::ACQD_CMD_OFFSET_CAL)
        zero_pt[cmd.chan] <= raw_sample[cmd.chan];
      if (cmd.kind == acqd_pkg::ACQD_CMD_GAIN_CAL)
        span_pt[cmd.chan] <= raw_sample[cmd.chan];
    end
  end

  // ---------------- display views ----------------
  acqd_view_t view_r;
  acqd_view_t view_nxt;
  logic sel_ch_r;
  logic [DW-1:0] dwell_r;
  logic [CW-1:0] code_r;
  logic dwell_done;
  logic showing_code;

  assign dwell_done = (dwell_r == '0);
  assign showing_code = (code_r != '0);

  // mode key cycles single, cyclic, off
  always_comb begin
    case (view_r)
      ACQD_VIEW_SINGLE: view_nxt = ACQD_VIEW_CYCLIC;
      ACQD_VIEW_CYCLIC: view_nxt = ACQD_VIEW_OFF;
      ACQD_VIEW_OFF: view_nxt = ACQD_VIEW_SINGLE;
      default: view_nxt = ACQD_VIEW_SINGLE;
    endcase
  end

  // view, selected channel and the two interval counters
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      view_r <= ACQD_VIEW_SINGLE;
      sel_ch_r <= 1'b0;
      dwell_r <= DW'(DWELL_CYCLES - 1);
      code_r <= '0;
    end else if (mode_press) begin
      view_r <= view_nxt;
      dwell_r <= DW'(DWELL_CYCLES - 1);
      code_r <= (view_nxt == ACQD_VIEW_OFF) ? '0 :
                CW'(CODE_CYCLES);
    end else begin
      if (showing_code) code_r <= code_r - CW'(1);
      if (view_r == ACQD_VIEW_SINGLE) begin
        if (left_press) sel_ch_r <= step_ch(sel_ch_r, 1'b1);
        else if (right_press)
          sel_ch_r <= step_ch(sel_ch_r, 1'b0);
      end else if (view_r == ACQD_VIEW_CYCLIC) begin
        if (dwell_done) begin
          sel_ch_r <= step_ch(sel_ch_r, 1'b1);
          dwell_r <= DW'(DWELL_CYCLES - 1);
        end else begin
          dwell_r <= dwell_r - DW'(1);
        end
      end
    end
  end

  // ---------------- readout composition ----------------
  acqd_pkg::acqd_reading_t shown;
  acqd_pkg::acqd_disp_t data_disp;
  acqd_pkg::acqd_disp_t code_disp;
  acqd_pkg::acqd_disp_t disp_nxt;
  acqd_pkg::acqd_disp_t dark_disp;
  logic [3:0] ch_glyph;
  logic [2:0] frac_dp;

  assign shown = reading[sel_ch_r];
  assign ch_glyph = sel_ch_r ? 4'h2 : 4'h1;
  // point between integer and fraction among the three value digits
  assign frac_dp = (shown.dp_pos == 2'h0) ? 3'h1 :
                   (shown.dp_pos == 2'h1) ? 3'h2 : 3'h4;
  assign data_disp = '{glyph: {ch_glyph, shown.bcd},
                       dp: {shown.positive, frac_dp},
                       on: 1'b1};
  // view code shows as letter C and view number in the two left digits
  assign code_disp = '{glyph: {acqd_pkg::GLYPH_C,
                               (view_r == ACQD_VIEW_CYCLIC) ? 4'h2 : 4'h1,
                               acqd_pkg::GLYPH_BLANK,
                               acqd_pkg::GLYPH_BLANK},
                       dp: 4'h0, on: 1'b1};
  // dark readout named so the selection below stays a plain mux
  assign dark_disp = '{glyph: {4{acqd_pkg::GLYPH_BLANK}}, dp: 4'h0,
                       on: 1'b0};
  assign disp_nxt = (view_r == ACQD_VIEW_OFF) ? dark_disp :
                    (showing_code ? code_disp : data_disp);

  // registered so the segment drivers see no decode glitches
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      disp <= '{glyph: {4{acqd_pkg::GLYPH_BLANK}}, dp: 4'h0, on: 1'b0};
    end else begin
      disp <= disp_nxt;
    end
  end

endmodule // acqd_top

// ### testbench/acqd_host_model.sv
// host side model: issues decoded commands and sets the analog source
`timescale 1ns/100ps
module acqd_host_model #(
  parameter int SAMPLE_W = 24,
  parameter int SETTLE = 4
) (
  // clock
  input wire logic clk_sys,
  // command path toward the block
  output acqd_pkg::acqd_cmd_t cmd,
  output logic cmd_valid,
  input wire logic cmd_ok,
  input wire logic cmd_err,
  // analog source applied by the host
  output logic [1:0][SAMPLE_W-1:0] raw_sample
);
  // idle until asked
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    raw_sample = '0;
  end

  // one command; the answer stands a single cycle, so grab it then
  task automatic send(input acqd_pkg::acqd_cmd_t c, output logic [1:0] ans);
    @(negedge clk_sys);
    cmd = c;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    ans = {cmd_ok, cmd_err};
    cmd_valid = 1'b0;
    cmd = ~c; // stale fields scrambled so nothing relies on them
  endtask

  // apply the source level, let it settle, then ask for the store
  task automatic calibrate(input acqd_pkg::acqd_cmd_kind_t k, input logic ch,
      input logic [SAMPLE_W-1:0] v, output logic [1:0] ans);
    acqd_pkg::acqd_cmd_t c;
    @(negedge clk_sys);
    raw_sample[ch] = v;
    repeat (SETTLE) @(negedge clk_sys);
    c = '0;
    c.kind = k;
    c.chan = ch;
    send(c, ans);
  endtask
endmodule // acqd_host_model

// ### testbench/acqd_assertions.sv
// port checks for the acquisition display controller
`timescale 1ns/100ps
module acqd_chk #(
  parameter int SAMPLE_W = 24
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // command path
  input wire logic cmd_valid,
  input wire acqd_pkg::acqd_cmd_t cmd,
  input wire logic cmd_ok,
  input wire logic cmd_err,
  // live settings
  input wire acqd_pkg::acqd_cfg_t cfg,
  input wire logic config_state,
  input wire logic [23:0] char_cycles,
  // samples, calibration points, readout
  input wire logic [1:0][SAMPLE_W-1:0] raw_sample,
  input wire acqd_pkg::acqd_reading_t [1:0] reading,
  input wire logic [1:0][SAMPLE_W-1:0] zero_pt,
  input wire logic [1:0][SAMPLE_W-1:0] span_pt,
  input wire acqd_pkg::acqd_disp_t disp
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // previous-cycle copies: answers and readout lag their cause by one
  acqd_pkg::acqd_cmd_t cmd_q;
  acqd_pkg::acqd_cfg_t cfg_q;
  acqd_pkg::acqd_reading_t [1:0] rd_q;
  logic [1:0][SAMPLE_W-1:0] raw_q;
  logic valid_q;
  always_ff @(posedge clk_sys) begin
    cmd_q <= cmd;
    cfg_q <= cfg;
    rd_q <= reading;
    raw_q <= raw_sample;
    valid_q <= cmd_valid;
  end

  // decode of the command answered now
  wire is_off = cmd_q.kind == acqd_pkg::ACQD_CMD_OFFSET_CAL;
  wire is_gain = cmd_q.kind == acqd_pkg::ACQD_CMD_GAIN_CAL;
  wire is_proto = cmd_q.kind == acqd_pkg::ACQD_CMD_SET_PROTO;

  a_answer_cause: assert property ((cmd_ok || cmd_err) |-> valid_q)
    else $error("answer without a command");
  a_locked_settings: assert property ((cmd_ok && !config_state) |->
    cfg.baud == cfg_q.baud && cfg.cksum_en == cfg_q.cksum_en &&
    cfg.proto == cfg_q.proto) else $error("settings changed outside config");
  a_refuse_stable: assert property (cmd_err |-> cfg == cfg_q)
    else $error("refused command changed settings");
  a_cal_ascii: assert property ((cmd_ok && (is_off || is_gain)) |->
    cfg_q.proto == acqd_pkg::ACQD_PROTO_ASCII)
    else $error("calibration accepted under modbus");
  a_offset_store: assert property ((cmd_ok && is_off) |->
    zero_pt[cmd_q.chan] == raw_q[cmd_q.chan]) else $error("zero not stored");
  a_gain_store: assert property ((cmd_ok && is_gain) |->
    span_pt[cmd_q.chan] == raw_q[cmd_q.chan]) else $error("span not stored");
  a_proto_config: assert property ((cmd_ok && is_proto) |->
    config_state) else $error("protocol set outside config");
  a_config_entry: assert property ($rose(config_state) |->
    cfg == {acqd_pkg::ADDR_CONFIG, acqd_pkg::BAUD_9600, 2'h0})
    else $error("config entry settings wrong");
  a_char_length: assert property ((cfg.baud == 4'h6)[*2] |->
    char_cycles == 24'(10 * (acqd_pkg::CLK_HZ / 9600)))
    else $error("character time wrong");
  a_sign_point: assert property ((disp.on && disp.glyph[3] == 4'h1) |->
    disp.dp[3] == rd_q[0].positive) else $error("sign point wrong");
  a_chan_digit: assert property ((disp.on &&
    disp.glyph[3] != acqd_pkg::GLYPH_C) |-> disp.glyph[3] inside {4'h1, 4'h2})
    else $error("channel digit out of range");
  a_off_blank: assert property (!disp.on |->
    disp.glyph == {4{acqd_pkg::GLYPH_BLANK}}) else $error("dark but not blank");

  // main scenarios reached
  c_offset: cover property (cmd_ok && is_off);
  c_config: cover property ($rose(config_state));
  c_off: cover property ($fell(disp.on));
  c_code: cover property (disp.glyph[3] == acqd_pkg::GLYPH_C);
endmodule // acqd_chk

bind acqd_top acqd_chk #(.SAMPLE_W(SAMPLE_W)) acqd_chk_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
  .cmd_ok(cmd_ok), .cmd_err(cmd_err), .cfg(cfg),
  .config_state(config_state), .char_cycles(char_cycles),
  .raw_sample(raw_sample), .reading(reading), .zero_pt(zero_pt),
  .span_pt(span_pt), .disp(disp));

// ### testbench/test_acqd_top.sv
// self-checking bench for the acquisition display controller
`timescale 1ns/100ps
module test_acqd_top;
  localparam int DWELL = 20;
  localparam int CODE = 10;
  localparam acqd_pkg::acqd_cmd_kind_t K_CFG = acqd_pkg::ACQD_CMD_CONFIG;
  localparam acqd_pkg::acqd_cmd_kind_t K_PRO = acqd_pkg::ACQD_CMD_SET_PROTO;
  localparam acqd_pkg::acqd_cmd_kind_t K_OFF = acqd_pkg::ACQD_CMD_OFFSET_CAL;
  localparam acqd_pkg::acqd_cmd_kind_t K_GAIN = acqd_pkg::ACQD_CMD_GAIN_CAL;
  // stimulus and observed signals
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_strap_n = 1'b1;
  logic nv_cfg_valid = 1'b0;
  acqd_pkg::acqd_cfg_t nv_cfg = '0;
  logic [2:0] keys_n = 3'h7;
  acqd_pkg::acqd_reading_t [1:0] reading;
  acqd_pkg::acqd_cmd_t cmd;
  logic cmd_valid, cmd_ok, cmd_err, config_state;
  acqd_pkg::acqd_cfg_t cfg;
  logic [23:0] char_cycles;
  logic [1:0][23:0] raw_sample, zero_pt, span_pt;
  acqd_pkg::acqd_disp_t disp;
  logic [1:0] ans;
  logic [3:0] g;
  int rates[8] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400};
  int n_errors = 0;
  int checks = 0;

  always #10 clk_sys = ~clk_sys;

  acqd_top #(.DWELL_CYCLES(DWELL), .CODE_CYCLES(CODE), .SAMPLE_W(24))
    acqd_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_strap_n(cfg_strap_n),
    .nv_cfg_valid(nv_cfg_valid), .nv_cfg(nv_cfg), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ok(cmd_ok), .cmd_err(cmd_err), .cfg(cfg),
    .config_state(config_state), .char_cycles(char_cycles),
    .raw_sample(raw_sample), .reading(reading), .zero_pt(zero_pt),
    .span_pt(span_pt), .key_mode_n(keys_n[0]), .key_left_n(keys_n[1]),
    .key_right_n(keys_n[2]), .disp(disp));
  acqd_host_model #(.SAMPLE_W(24)) acqd_host_model_inst (.clk_sys(clk_sys),
    .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ok(cmd_ok), .cmd_err(cmd_err),
    .raw_sample(raw_sample));

  // helpers: compare, reset, commands, keys, readout
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic do_reset(input logic strap_n, input logic nvv);
    @(negedge clk_sys);
    rst_n = 1'b0;
    cfg_strap_n = strap_n;
    nv_cfg_valid = nvv;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (6) @(negedge clk_sys);
  endtask
  function automatic logic [23:0] cc(input int r);
    return 24'(10 * (acqd_pkg::CLK_HZ / r));
  endfunction
  task automatic sd(input acqd_pkg::acqd_cmd_kind_t k, input logic [7:0] a,
      input logic [3:0] b, input logic c, input logic p);
    acqd_host_model_inst.send({k, 1'b0, a, b, c, p}, ans);
  endtask
  task automatic cal(input acqd_pkg::acqd_cmd_kind_t k, input logic ch,
      input logic [23:0] v);
    acqd_host_model_inst.calibrate(k, ch, v, ans);
  endtask
  task automatic press(input int k);
    @(negedge clk_sys);
    keys_n[k] = 1'b0;
    repeat (3) @(negedge clk_sys);
    keys_n = 3'h7;
    repeat (4) @(negedge clk_sys);
  endtask
  function automatic logic shows(input int ch);
    acqd_pkg::acqd_reading_t r;
    r = reading[ch];
    return disp.on === 1'b1 && disp.glyph[3] === 4'(ch + 1) &&
      disp.glyph[2:0] === r.bcd && disp.dp === {r.positive, 3'(1 << r.dp_pos)};
  endfunction

  // factory defaults, then locked settings outside config
  task automatic t_normal;
    do_reset(1'b1, 1'b0);
    check(cfg === {8'h01, 4'h6, 2'h0} && !config_state, "defaults");
    check(char_cycles === cc(9600), "char time");
    sd(K_CFG, 8'h5A, 4'h6, 1'b0, 1'b0); // distinct node address
    check(ans === 2'h2 && cfg.addr === 8'h5A, "address");
    sd(acqd_pkg::acqd_cmd_kind_t'(3'h5), 8'h11, 4'h6, 1'b0, 1'b0);
    check(ans === 2'h1 && cfg.addr === 8'h5A, "unknown kind");
    sd(K_CFG, 8'h77, 4'h8, 1'b0, 1'b0);
    check(ans === 2'h1 && cfg === {8'h5A, 4'h6, 2'h0}, "baud lock");
    sd(K_CFG, 8'h77, 4'h6, 1'b1, 1'b0);
    check(ans === 2'h1 && cfg.cksum_en === 1'b0, "cksum lock");
    sd(K_PRO, 8'h00, 4'h0, 1'b0, 1'b1);
    check(ans === 2'h1 && cfg.proto === 1'b0, "proto lock");
    cal(K_OFF, 1'b1, 24'h00ABCD);
    check(ans === 2'h2 && zero_pt[1] === 24'h00ABCD, "offset");
    cal(K_GAIN, 1'b0, 24'h7FFFFF);
    check(ans === 2'h2 && span_pt[0] === 24'h7FFFFF, "gain");
  endtask

  // stored modbus settings refuse calibration
  task automatic t_stored;
    nv_cfg = {8'h33, 4'h7, 1'b1, 1'b1};
    do_reset(1'b1, 1'b1);
    check(cfg === nv_cfg && char_cycles === cc(19200), "stored");
    cal(K_OFF, 1'b0, 24'h000111);
    check(ans === 2'h1 && zero_pt[0] === 24'h000000, "modbus cal");
  endtask

  // strap held low: every baud code, protocol select
  task automatic t_config;
    do_reset(1'b0, 1'b0);
    check(config_state === 1'b1 && cfg === {8'h00, 4'h6, 2'h0}, "entry");
    for (int i = 1; i <= 8; i++) begin
      sd(K_CFG, 8'h00, 4'(i), 1'b1, 1'b0);
      @(negedge clk_sys);
      check(ans === 2'h2 && cfg.baud === 4'(i) && cfg.cksum_en === 1'b1 &&
        char_cycles === cc(rates[i-1]), "baud code");
    end
    sd(K_CFG, 8'h00, 4'h9, 1'b1, 1'b0);
    check(ans === 2'h1 && cfg.baud === 4'h8, "bad baud");
    sd(K_PRO, 8'h00, 4'h0, 1'b0, 1'b1);
    check(ans === 2'h2 && cfg.proto === 1'b1, "modbus");
    cal(K_GAIN, 1'b1, 24'h123456);
    check(ans === 2'h1 && span_pt[1] === 24'h000000, "no cal");
    sd(K_PRO, 8'h00, 4'h0, 1'b0, 1'b0);
    check(ans === 2'h2 && cfg.proto === 1'b0, "ascii");
  endtask

  // readout, channel keys, view cycle
  task automatic t_display;
    do_reset(1'b1, 1'b0);
    check(shows(0), "first view");
    press(1);
    check(shows(1), "left");
    press(1);
    check(shows(0), "left wrap");
    press(2);
    check(shows(1), "right wrap");
    press(2);
    check(shows(0), "right");
    press(0);
    check(disp.glyph === {4'hC, 4'h2, 8'hFF}, "cyclic code");
    repeat (CODE + 2) @(negedge clk_sys);
    g = disp.glyph[3];
    check(shows(0) || shows(1), "data back");
    repeat (DWELL) @(negedge clk_sys);
    check(disp.glyph[3] !== g && (shows(0) || shows(1)), "step");
    repeat (DWELL) @(negedge clk_sys);
    check(disp.glyph[3] === g, "step back");
    press(0);
    check(disp.on === 1'b0, "off");
    press(1);
    check(disp.on === 1'b0, "off holds");
    press(0);
    check(disp.glyph[3:2] === {4'hC, 4'h1}, "single code");
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    $display("[FAIL] %0t run too long", $time);
    results();
  end

  initial begin
    reading[0] = {1'b1, 12'h123, 2'h1};
    reading[1] = {1'b0, 12'h456, 2'h0};
    t_normal();
    t_stored();
    t_config();
    t_display();
    results();
  end
endmodule // test_acqd_top
